// *** rail_strobe_regs.svh ***
// Summary of operation
// - Second backup buck step field is bits 5-4, reset 1h; 1h step 1, 2h step 2.
// - First backup buck step field is bits 1-0, reset 1h; same step 1/2 decode.
// - Backup codes 0h and 3h keep that rail away from the sequencer entirely.
// - Steps 1 and 2 run only while the freshness seal flag is 0.
// - Once the seal is broken the sequencer never disables either backup buck.
// - Switch/regulator step register sits at index 25h and resets to 88h.
// - Load switch field is bits 7-4, reset 8h; codes 3h..Ah select steps 3..10.
// - Load switch codes 0h-2h and Bh-Fh leave the switch unsequenced.
// - Regulator field is bits 3-0, reset 8h, same decode as the load switch.
`ifndef RAIL_STROBE_REGS_SVH
`define RAIL_STROBE_REGS_SVH
`define IDX_BACKUP       8'h24
`define IDX_SWITCH_LDO   8'h25
`define IDX_STATUS       8'h28
`define RST_BACKUP       8'h11
`define RST_SWITCH_LDO   8'h88
`define BACKUP_WMASK     8'h33
`define FLD_BUCK_B_HI    5
`define FLD_BUCK_B_LO    4
`define FLD_BUCK_A_HI    1
`define FLD_BUCK_A_LO    0
`define FLD_SWITCH_HI    7
`define FLD_SWITCH_LO    4
`define FLD_GP_HI        3
`define FLD_GP_LO        0
`define STEP_FIRST       4'h1
`define STEP_WIDE_FIRST  4'h3
`define STEP_LAST        4'ha
`define STEP_CYCLES_DEF  16
`define BK_CODE_FIRST    2'h1
`define BK_CODE_LAST     2'h2
`define STEP_BACKUP_LAST 4'h2
`endif

// *** rail_strobe_pkg.sv ***
package rail_strobe_pkg;
    // Sequencer-driven rail enables.
    typedef struct packed {
        logic buck_a;
        logic buck_b;
        logic lv_switch;
        logic gp_regulator;
    } rail_en_t;
    // Avalon-MM request carrier.
    typedef struct packed {
        logic [9:0]  address;
        logic        read;
        logic        write;
        logic [3:0]  byteenable;
        logic [31:0] writedata;
    } avs_req_t;
    typedef enum logic [2:0] {
        SEQ_IDLE = 3'b001,
        SEQ_UP   = 3'b010,
        SEQ_DOWN = 3'b100
    } seq_state_t;
endpackage

// *** rail_strobe_assignment.sv ***
// Chosen here: the Avalon-MM interface to the registers.
`timescale 1ns/1ps
`include "rail_strobe_regs.svh"
module rail_strobe_assignment #(
    parameter int STEP_CYCLES = `STEP_CYCLES_DEF
) (
    input  wire logic                       clk,
    input  wire logic                       arst_n,
    input  wire logic                       ce,
    input  wire rail_strobe_pkg::avs_req_t  avs_req,
    output logic [31:0]                     avs_readdata,
    output logic                            avs_waitrequest,
    input  wire logic                       write_unlock,
    input  wire logic                       freshness_seal_flag,
    input  wire logic                       seq_power_up,
    input  wire logic                       seq_power_down,
    output rail_strobe_pkg::rail_en_t       rails,
    output logic [3:0]                      seq_step,
    output logic                            seq_busy
);
    import rail_strobe_pkg::*;

    logic [1:0]  rst_sync_q;
    logic        rst_n;
    logic [7:0]  backup_q;
    logic [7:0]  switch_ldo_q;
    logic        wait_q;
    logic [31:0] rdata_q;
    seq_state_t  state_q;
    logic [3:0]  step_q;
    logic [15:0] timer_q;
    logic        busy_q;
    rail_en_t    rails_q;
    logic        req;
    logic        take;
    logic [7:0]  idx;
    logic        tick;
    logic [1:0]  buck_a_fld;
    logic [1:0]  buck_b_fld;
    logic [3:0]  sw_fld;
    logic [3:0]  gp_fld;

    // Backup code matches step only for codes 1h and 2h; 0h and 3h never match.
    function automatic logic hit2(input logic [1:0] f, input logic [3:0] s);
        hit2 = (f == `BK_CODE_FIRST || f == `BK_CODE_LAST) && ({2'h0, f} == s);
    endfunction

    // Wide code matches step only within 3h..Ah.
    function automatic logic hit4(input logic [3:0] f, input logic [3:0] s);
        hit4 = (f >= `STEP_WIDE_FIRST) && (f <= `STEP_LAST) && (f == s);
    endfunction

    // Reset release through two flip-flops.
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            rst_sync_q <= 2'h0;
        end else begin
            rst_sync_q <= {rst_sync_q[0], 1'b1};
        end
    end
    assign rst_n = rst_sync_q[1];

    // Field views and bus decode.
    assign buck_a_fld = backup_q[`FLD_BUCK_A_HI:`FLD_BUCK_A_LO];
    assign buck_b_fld = backup_q[`FLD_BUCK_B_HI:`FLD_BUCK_B_LO];
    assign sw_fld     = switch_ldo_q[`FLD_SWITCH_HI:`FLD_SWITCH_LO];
    assign gp_fld     = switch_ldo_q[`FLD_GP_HI:`FLD_GP_LO];
    assign req        = avs_req.read || avs_req.write;
    assign take       = req && !wait_q;
    assign idx        = avs_req.address[9:2];
    assign tick       = (timer_q == 16'(STEP_CYCLES - 1));

    // Waitrequest drops for one cycle after a request is seen, carrying read data.
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            wait_q  <= 1'b1;
            rdata_q <= 32'h0;
        end else if (ce) begin
            if (take || !req) begin
                wait_q <= 1'b1;
            end else begin
                wait_q <= 1'b0;
                case (idx)
                    `IDX_BACKUP:     rdata_q <= {24'h0, backup_q};
                    `IDX_SWITCH_LDO: rdata_q <= {24'h0, switch_ldo_q};
                    `IDX_STATUS:     rdata_q <= {20'h0, seq_busy, 1'b0, freshness_seal_flag, 1'b0,
                                                 rails_q.buck_a, rails_q.buck_b,
                                                 rails_q.lv_switch, rails_q.gp_regulator, step_q};
                    default:         rdata_q <= 32'h0;
                endcase
            end
        end
    end

    // Step registers; writes accepted only when unlocked, reserved bits stay zero.
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            backup_q     <= `RST_BACKUP;
            switch_ldo_q <= `RST_SWITCH_LDO;
        end else if (ce && take && avs_req.write && avs_req.byteenable[0] && write_unlock) begin
            if (idx == `IDX_BACKUP) begin
                backup_q <= avs_req.writedata[7:0] & `BACKUP_WMASK;
            end
            if (idx == `IDX_SWITCH_LDO) begin
                switch_ldo_q <= avs_req.writedata[7:0];
            end
        end
    end

    // Sequence walker: up from step 1 to 10, down from 10 to 1.
    // The busy flag is its own flip-flop so that the output carries no decode glitches.
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            state_q <= SEQ_IDLE;
            step_q  <= 4'h0;
            timer_q <= 16'h0;
            busy_q  <= 1'b0;
        end else if (ce) begin
            case (state_q)
                SEQ_IDLE: begin
                    timer_q <= 16'h0;
                    if (seq_power_up) begin
                        state_q <= SEQ_UP;
                        step_q  <= `STEP_FIRST;
                        busy_q  <= 1'b1;
                    end else if (seq_power_down) begin
                        state_q <= SEQ_DOWN;
                        step_q  <= `STEP_LAST;
                        busy_q  <= 1'b1;
                    end
                end
                SEQ_UP: begin
                    timer_q <= tick ? 16'h0 : timer_q + 16'h1;
                    if (tick) begin
                        if (step_q == `STEP_LAST) begin
                            state_q <= SEQ_IDLE;
                            step_q  <= 4'h0;
                            busy_q  <= 1'b0;
                        end else begin
                            step_q <= step_q + 4'h1;
                        end
                    end
                end
                SEQ_DOWN: begin
                    timer_q <= tick ? 16'h0 : timer_q + 16'h1;
                    if (tick) begin
                        if (step_q == `STEP_FIRST) begin
                            state_q <= SEQ_IDLE;
                            step_q  <= 4'h0;
                            busy_q  <= 1'b0;
                        end else begin
                            step_q <= step_q - 4'h1;
                        end
                    end
                end
                default: begin
                    state_q <= SEQ_IDLE;
                    step_q  <= 4'h0;
                    busy_q  <= 1'b0;
                end
            endcase
        end
    end

    // Rail enables change on the first cycle of each step.
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            rails_q <= '0;
        end else if (ce && timer_q == 16'h0) begin
            if (state_q == SEQ_UP) begin
                if (!freshness_seal_flag) begin
                    if (hit2(buck_a_fld, step_q)) rails_q.buck_a <= 1'b1;
                    if (hit2(buck_b_fld, step_q)) rails_q.buck_b <= 1'b1;
                end
                if (hit4(sw_fld, step_q)) rails_q.lv_switch <= 1'b1;
                if (hit4(gp_fld, step_q)) rails_q.gp_regulator <= 1'b1;
            end else if (state_q == SEQ_DOWN) begin
                if (!freshness_seal_flag) begin
                    if (hit2(buck_a_fld, step_q)) rails_q.buck_a <= 1'b0;
                    if (hit2(buck_b_fld, step_q)) rails_q.buck_b <= 1'b0;
                end
                if (hit4(sw_fld, step_q)) rails_q.lv_switch <= 1'b0;
                if (hit4(gp_fld, step_q)) rails_q.gp_regulator <= 1'b0;
            end
        end
    end

    assign avs_readdata    = rdata_q;
    assign avs_waitrequest = wait_q;
    assign rails           = rails_q;
    assign seq_step        = step_q;
    assign seq_busy        = busy_q;

    property p_wait_one;
        @(posedge clk) disable iff (!rst_n) (ce && req && wait_q) |=> (!wait_q ##1 (wait_q || !ce));
    endproperty
    a_wait_one: assert property (p_wait_one) else $error("Waitrequest not low for one cycle.");

    property p_reserved_zero;
        @(posedge clk) disable iff (!rst_n) 1'b1 |-> (backup_q & ~`BACKUP_WMASK) == 8'h0;
    endproperty
    a_reserved_zero: assert property (p_reserved_zero) else $error("Reserved backup bits set.");

    property p_locked_write;
        @(posedge clk) disable iff (!rst_n) (take && avs_req.write && !write_unlock) |=>
            ($stable(backup_q) && $stable(switch_ldo_q));
    endproperty
    a_locked_write: assert property (p_locked_write) else $error("Locked write changed a register.");

    property p_buck_a_on;
        @(posedge clk) disable iff (!rst_n) $rose(rails_q.buck_a) |->
            ($past(step_q) == {2'h0, $past(buck_a_fld)} && !$past(freshness_seal_flag) &&
             $past(step_q) <= `STEP_BACKUP_LAST);
    endproperty
    a_buck_a_on: assert property (p_buck_a_on) else $error("Backup buck A enabled at wrong step.");

    property p_buck_b_on;
        @(posedge clk) disable iff (!rst_n) $rose(rails_q.buck_b) |->
            ($past(buck_b_fld) inside {`BK_CODE_FIRST, `BK_CODE_LAST} && $past(state_q) == SEQ_UP);
    endproperty
    a_buck_b_on: assert property (p_buck_b_on) else $error("Backup buck B enabled by bad code.");

    property p_seal_hold;
        @(posedge clk) disable iff (!rst_n) ($fell(rails_q.buck_a) || $fell(rails_q.buck_b)) |->
            !$past(freshness_seal_flag);
    endproperty
    a_seal_hold: assert property (p_seal_hold) else $error("Backup buck disabled after seal broken.");

    property p_switch_code;
        @(posedge clk) disable iff (!rst_n) $changed(rails_q.lv_switch) |->
            ($past(sw_fld) >= `STEP_WIDE_FIRST && $past(sw_fld) <= `STEP_LAST && $past(sw_fld) == $past(step_q));
    endproperty
    a_switch_code: assert property (p_switch_code) else $error("Load switch moved on bad code.");

    property p_gp_code;
        @(posedge clk) disable iff (!rst_n) $rose(rails_q.gp_regulator) |->
            ($past(gp_fld) == $past(step_q) && $past(gp_fld) >= `STEP_WIDE_FIRST);
    endproperty
    a_gp_code: assert property (p_gp_code) else $error("Regulator enabled at wrong step.");

    property p_ascend;
        @(posedge clk) disable iff (!rst_n) (ce && state_q == SEQ_UP && tick && step_q != `STEP_LAST) |=>
            (step_q == $past(step_q) + 4'h1);
    endproperty
    a_ascend: assert property (p_ascend) else $error("Up sequence did not advance by one.");
endmodule

// *** tb_rail_strobe_assignment.sv ***
`timescale 1ns/1ps
`include "rail_strobe_regs.svh"
module tb_rail_strobe_assignment;
    import rail_strobe_pkg::*;
    logic                 clk;
    logic                 arst_n;
    logic                 ce;
    avs_req_t             avs_req;
    logic [31:0]          avs_readdata;
    logic                 avs_waitrequest;
    logic                 write_unlock;
    logic                 seal;
    logic                 pwr_up;
    logic                 pwr_dn;
    rail_en_t             rails;
    logic [3:0]           seq_step;
    logic                 seq_busy;
    logic [31:0]          rd;
    logic [3:0]           on_step [4];
    int                   n_mismatch = 0;
    int                   n_checks = 0;

    rail_strobe_assignment #(.STEP_CYCLES(2)) dut (
        .clk(clk), .arst_n(arst_n), .ce(ce), .avs_req(avs_req), .avs_readdata(avs_readdata),
        .avs_waitrequest(avs_waitrequest), .write_unlock(write_unlock), .freshness_seal_flag(seal),
        .seq_power_up(pwr_up), .seq_power_down(pwr_dn), .rails(rails), .seq_step(seq_step),
        .seq_busy(seq_busy));

    // The clock toggles every half period of 5 ns.
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    // Compares one result and counts it.
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_checks++;
        if (got !== exp) begin
            n_mismatch++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    // One bus cycle; the request is held until waitrequest is seen low at an edge.
    task automatic bus(input logic wr, input logic [9:0] a, input logic [31:0] d, input logic [3:0] be);
        @(posedge clk);
        avs_req.address <= a;
        avs_req.read <= ~wr;
        avs_req.write <= wr;
        avs_req.writedata <= d;
        avs_req.byteenable <= be;
        do @(posedge clk); while (avs_waitrequest !== 1'b0);
        rd = avs_readdata;
        avs_req.read <= 1'b0;
        avs_req.write <= 1'b0;
    endtask

    // Holds reset for four cycles, then waits out the release synchroniser.
    task automatic do_reset();
        arst_n <= 1'b0;
        repeat (4) @(posedge clk);
        arst_n <= 1'b1;
        repeat (3) @(posedge clk);
    endtask

    // Runs one sequence and records the step at which each rail first rises.
    task automatic run_seq(input logic up);
        logic [3:0] prev;
        logic [3:0] r;
        int         k;
        prev = 4'h0;
        for (int i = 0; i < 4; i++) on_step[i] = 4'h0;
        @(posedge clk);
        if (up) pwr_up <= 1'b1;
        else pwr_dn <= 1'b1;
        @(posedge clk);
        pwr_up <= 1'b0;
        pwr_dn <= 1'b0;
        k = 0;
        do begin
            @(posedge clk);
            r = rails;
            for (int i = 0; i < 4; i++) if (r[i] === 1'b1 && on_step[i] == 4'h0) on_step[i] = seq_step;
            if (up && seq_busy === 1'b1) begin
                chk({31'h0, seq_step >= prev}, 32'h1);
                prev = seq_step;
            end
            k++;
        end while ((seq_busy !== 1'b0 || k < 2) && k < 200);
        chk({31'h0, k < 200}, 32'h1);
    endtask

    // Compares the recorded first-on steps: buck_a, buck_b, lv_switch, gp_regulator.
    task automatic chk_steps(input logic [15:0] exp);
        chk({28'h0, on_step[3]}, {28'h0, exp[15:12]});
        chk({28'h0, on_step[2]}, {28'h0, exp[11:8]});
        chk({28'h0, on_step[1]}, {28'h0, exp[7:4]});
        chk({28'h0, on_step[0]}, {28'h0, exp[3:0]});
    endtask

    task automatic end_of_test();
        $display("checks %0d mismatches %0d", n_checks, n_mismatch);
        if (n_mismatch == 0 && n_checks > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask

    // A hang is cut off well beyond the few hundred cycles that the tests need.
    initial begin
        #200000;
        n_mismatch++;
        end_of_test();
    end

    // Main sequence of tests.
    initial begin
        arst_n = 1'b0;
        ce = 1'b1;
        avs_req = '0;
        write_unlock = 1'b1;
        seal = 1'b0;
        pwr_up = 1'b0;
        pwr_dn = 1'b0;
        do_reset();
        bus(1'b0, 10'h090, 32'h0, 4'hf); chk(rd, 32'h11);
        bus(1'b0, 10'h094, 32'h0, 4'hf); chk(rd, 32'h88);
        bus(1'b0, 10'h3fc, 32'h0, 4'hf); chk(rd, 32'h0);
        $display("test reset_values done");
        bus(1'b1, 10'h090, 32'hff, 4'hf);
        bus(1'b0, 10'h090, 32'h0, 4'hf); chk(rd, 32'h33);
        write_unlock <= 1'b0;
        bus(1'b1, 10'h094, 32'h00, 4'hf);
        bus(1'b0, 10'h094, 32'h0, 4'hf); chk(rd, 32'h88);
        write_unlock <= 1'b1;
        bus(1'b1, 10'h094, 32'h00, 4'he);
        bus(1'b0, 10'h094, 32'h0, 4'hf); chk(rd, 32'h88);
        $display("test write_rules done");
        bus(1'b1, 10'h090, 32'h21, 4'hf);
        bus(1'b1, 10'h094, 32'h3a, 4'hf);
        run_seq(1'b1);
        chk_steps(16'h123a);
        bus(1'b0, 10'h0a0, 32'h0, 4'hf); chk(rd, 32'hf0);
        $display("test power_up_order done");
        seal <= 1'b1;
        run_seq(1'b0);
        chk({28'h0, rails}, 32'hc);
        // Status shows the seal flag set and both backup rails still on.
        bus(1'b0, 10'h0a0, 32'h0, 4'hf); chk(rd, 32'h2c0);
        $display("test sealed_down done");
        do_reset();
        run_seq(1'b1);
        chk_steps(16'h0088);
        $display("test sealed_up done");
        do_reset();
        seal <= 1'b0;
        bus(1'b1, 10'h090, 32'h30, 4'hf);
        bus(1'b1, 10'h094, 32'hb2, 4'hf);
        run_seq(1'b1);
        chk_steps(16'h0000);
        do_reset();
        bus(1'b1, 10'h090, 32'h03, 4'hf);
        bus(1'b1, 10'h094, 32'h2f, 4'hf);
        run_seq(1'b1);
        chk_steps(16'h0000);
        $display("test unsequenced_codes done");
        // A start request while the clock enable is low must leave the walker idle.
        ce <= 1'b0;
        pwr_up <= 1'b1;
        repeat (3) @(posedge clk);
        pwr_up <= 1'b0;
        ce <= 1'b1;
        repeat (3) @(posedge clk);
        chk({31'h0, seq_busy}, 32'h0);
        $display("test clock_enable done");
        end_of_test();
    end
endmodule
